// [dma_burst_cfg.svh]
`ifndef DMA_BURST_CFG_SVH
`define DMA_BURST_CFG_SVH

// ****************************************************************
// register map
// ****************************************************************
`define VENDOR_BASE 12'h800
`define ISO_CTRL_OFS 12'h800
`define ASYNC_CTRL_OFS 12'h808
`define LINK_OPT_OFS 12'h840

// ****************************************************************
// reset values and field masks
// ****************************************************************
`define ISO_CTRL_RESET 32'h0000_7373
`define ASYNC_CTRL_RESET 32'h0010_7373
`define LINK_OPT_RESET 32'h0000_0020
`define ISO_CTRL_MASK 32'h0000_ffff
`define ASYNC_CTRL_MASK 32'h01ff_ffff
`define LINK_OPT_MASK 32'hbf00_003f

// ****************************************************************
// field positions
// ****************************************************************
`define TX_BURST_LSB 12
`define TX_LEVEL_LSB 8
`define RX_BURST_LSB 4
`define RX_LEVEL_LSB 0
`define READY_LEVEL_LSB 16
`define RETRY_MAX_BIT 24
`define READY_LEVEL_MAX 8'h20

// ****************************************************************
// eeprom image slots
// ****************************************************************
`define ROM_SLOT_ISO 2'h0
`define ROM_SLOT_ASYNC 2'h1
`define ROM_SLOT_LINK 2'h2

`endif

// [dma_burst_checker.sv]
`timescale 1ns/1ps
// ********
// port checker
// ********
module dma_burst_checker
	import dma_burst_pkg::*;
(
	// pci side
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire reg_req_type reg_req,
	input wire logic reg_rvalid,
	input wire dma_stat_type iso_tx_stat,
	input wire dma_stat_type async_rx_stat,
	input wire dma_grant_type iso_tx_grant,
	input wire dma_grant_type async_rx_grant,
	// link side
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire link_stat_type link_stat,
	input wire logic async_tx_ready
);
	rd_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rvalid |-> $past(reg_req.sel && !reg_req.wr && reg_req.addr[11]))
		else $error("stray read data");
	low_half_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_req.sel && !reg_req.addr[11] |=> !reg_rvalid)
		else $error("lower half answered");
	tx_burst_pkt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		iso_tx_grant.bus_req |-> iso_tx_grant.burst <= $past(iso_tx_stat.pkt_len))
		else $error("burst above packet");
	tx_req_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		iso_tx_grant.bus_req |-> $past(iso_tx_stat.remain != 0 && iso_tx_stat.fifo_level < 512))
		else $error("tx request without space");
	rx_req_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		async_rx_grant.bus_req |-> $past(async_rx_stat.fifo_level) != 10'h0
		&& async_rx_grant.burst <= $past(async_rx_stat.fifo_level))
		else $error("rx request without data");
	ready_full_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		link_stat.fill >= 10'h200 |=> async_tx_ready)
		else $error("full fifo not ready");
	ready_whole_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		link_stat.pkt_whole && link_stat.fill != 10'h0 |=> async_tx_ready)
		else $error("whole packet not ready");
	ready_cause_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		async_tx_ready |-> $past(link_stat.fill) != 10'h0)
		else $error("ready on empty fifo");
	rd_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n) reg_rvalid);
	tx_req_c: cover property (@(posedge sys_clk) disable iff (!rst_n) iso_tx_grant.bus_req);
	ready_c: cover property (@(posedge link_clk) disable iff (!link_rst_n) async_tx_ready);
endmodule

bind dma_burst_threshold_control dma_burst_checker dma_burst_checker_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
	.iso_tx_stat(iso_tx_stat), .async_rx_stat(async_rx_stat), .iso_tx_grant(iso_tx_grant),
	.async_rx_grant(async_rx_grant), .link_clk(link_clk), .link_rst_n(link_rst_n),
	.link_stat(link_stat), .async_tx_ready(async_tx_ready));

// [dma_burst_pkg.sv]
package dma_burst_pkg;

	typedef enum logic [1:0] {
		ld_idle,
		ld_run,
		ld_done
	} load_state_type;

	// host memory-space register access
	typedef struct packed {
		logic sel;
		logic wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} reg_req_type;

	// one dma engine's status toward the arbiter
	typedef struct packed {
		logic [9:0] fifo_level;
		logic [15:0] remain;
		logic [15:0] buf_left;
		logic [9:0] pkt_len;
		logic [4:0] line_quads;
		logic pkt_whole;
	} dma_stat_type;

	// decision handed back to a dma engine
	typedef struct packed {
		logic bus_req;
		logic [8:0] burst;
	} dma_grant_type;

	typedef struct packed {
		load_state_type ld;
		logic [31:0] iso_q;
		logic [31:0] async_q;
		logic [31:0] link_q;
		logic [31:0] rdata_q;
		logic rvalid_q;
		dma_grant_type iso_tx_q;
		dma_grant_type iso_rx_q;
		dma_grant_type async_tx_q;
		dma_grant_type async_rx_q;
		logic [2:0] pkt_sync_q;
		logic [2:0] lnk_sync_q;
		logic ready_q;
	} state_type;

	typedef struct packed {
		logic [9:0] fill;
		logic [9:0] pkt_len;
		logic pkt_whole;
		logic retry;
	} link_stat_type;

endpackage

// [dma_burst_threshold_control.sv]
`timescale 1ns/1ps
`include "dma_burst_cfg.svh"
// Contract
// R01: vendor registers decode in upper 2K of the 4K base-address-0 region.
// R02: serial eeprom values, when present, replace the built-in register defaults.
// R03: software leaves these registers alone while the link is enabled.
// R04: iso transmit fetch burst at most 16*(n+1) quadlets, n bits 15:12.
// R05: iso transmit requests bus once free space reaches 16*(n+1), n bits 11:8.
// R06: iso transmit may request early when remaining data is below free space.
// R07: iso receive write burst at most 16*(n+1) quadlets, n bits 7:4.
// R08: iso receive requests bus once fifo data reaches 16*(n+1), n bits 3:0.
// R09: iso receive requests early if data exceeds buffer space or packet complete.
// R10: bit 24 set makes retried async packets use ready threshold 0x20.
// R11: link told packet ready once 16*n quadlets sit in async fifo.
// R12: link told packet ready whenever whole packet is in the fifo.
// R13: async transmit and read-response fetch at most 16*(n+1), n bits 15:12.
// R14: async transmit requests bus once free space reaches 16*(n+1), n 11:8.
// R15: async transmit may request early when remaining data is below free space.
// R16: async receive and physical write burst at most 16*(n+1), n bits 7:4.
// R17: async receive requests bus once fifo data reaches 16*(n+1), n 3:0.
// R18: async receive requests early if data exceeds buffer space or packet complete.
// R19: iso control register resets to 0x00007373.
// R20: async control register resets to 0x00107373.
// R21: actual burst also limited by packet, buffer, fifo and cache line.
// R22: unassigned control bits read zero and ignore writes.
module dma_burst_threshold_control
	import dma_burst_pkg::*;
(
	// pci clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register access in memory space of base address 0
	input wire reg_req_type reg_req,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// eeprom preload image
	input wire logic rom_present,
	input wire logic rom_valid,
	input wire logic [1:0] rom_slot,
	input wire logic [31:0] rom_data,
	output logic rom_busy,
	// dma engine status
	input wire dma_stat_type iso_tx_stat,
	input wire dma_stat_type iso_rx_stat,
	input wire dma_stat_type async_tx_stat,
	input wire dma_stat_type async_rx_stat,
	// dma engine requests and burst sizes
	output dma_grant_type iso_tx_grant,
	output dma_grant_type iso_rx_grant,
	output dma_grant_type async_tx_grant,
	output dma_grant_type async_rx_grant,
	// link side
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire link_stat_type link_stat,
	output logic async_tx_ready
);

	localparam logic [9:0] fifo_depth = 10'h200;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [8:0] level16(input logic [3:0] n);
		level16 = {1'b0, n, 4'h0} + 9'h010;
	endfunction

	function automatic logic [8:0] min9(input logic [8:0] a, input logic [15:0] b);
		min9 = (b < {7'h00, a}) ? b[8:0] : a;
	endfunction

	// burst is the programmed maximum trimmed by the live limits
	function automatic logic [8:0] trim_burst(input logic [3:0] n, input dma_stat_type s,
			input logic [15:0] avail);
		logic [8:0] b;
		b = level16(n);
		b = min9(b, {6'h00, s.pkt_len});
		b = min9(b, s.buf_left);
		b = min9(b, avail);
		if (s.line_quads != 5'h00 && b > {4'h0, s.line_quads})
			b = b - (b % {4'h0, s.line_quads});
		trim_burst = b;
	endfunction

	// transmit side: wait for space unless the rest of the data fits
	function automatic logic tx_req(input logic [3:0] n, input dma_stat_type s);
		logic [9:0] space;
		space = fifo_depth - s.fifo_level;
		tx_req = (s.remain != 16'h0000) && (space != 10'h000) &&
			(({1'b0, space} >= {2'b00, level16(n)}) || (s.remain < {6'h00, space}));
	endfunction

	// receive side: wait for data unless the buffer or a packet forces it
	function automatic logic rx_req(input logic [3:0] n, input dma_stat_type s);
		rx_req = (s.fifo_level != 10'h000) &&
			(({1'b0, s.fifo_level} >= {2'b00, level16(n)}) ||
			({6'h00, s.fifo_level} > s.buf_left) || s.pkt_whole);
	endfunction

	state_type s_q;
	state_type s_d;
	logic [9:0] space_it;
	logic [9:0] space_at;

	// ****************************************************************
	// link clock domain: ready decision
	// ****************************************************************
	logic [2:0] cfg_sync_q;
	logic [7:0] lvl_lnk_q;
	logic retry_max_lnk_q;
	logic ready_lnk_q;
	logic [31:0] async_snap_q;
	logic [8:0] eff_level;

	// register is static while link runs, so a settled copy is safe to sample
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cfg_sync_q <= 3'h0;
			lvl_lnk_q <= 8'h10;
			retry_max_lnk_q <= 1'b0;
		end else begin
			cfg_sync_q <= {cfg_sync_q[1:0], s_q.ld == ld_done};
			if (cfg_sync_q[2] && cfg_sync_q[1]) begin
				lvl_lnk_q <= async_snap_q[`READY_LEVEL_LSB +: 8];
				retry_max_lnk_q <= async_snap_q[`RETRY_MAX_BIT];
			end
		end
	end

	always_comb begin
		// R10 retry uses maximum
		if (link_stat.retry && retry_max_lnk_q)
			eff_level = {1'b0, `READY_LEVEL_MAX};
		else if (lvl_lnk_q > `READY_LEVEL_MAX)
			eff_level = {1'b0, `READY_LEVEL_MAX};
		else
			eff_level = {1'b0, lvl_lnk_q};
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ready_lnk_q <= 1'b0;
		end else begin
			// R11 R12 threshold or whole packet
			ready_lnk_q <= (link_stat.fill != 10'h000) &&
				(({1'b0, link_stat.fill} >= {1'b0, eff_level[5:0], 4'h0}) ||
				link_stat.pkt_whole);
		end
	end

	assign async_tx_ready = ready_lnk_q;

	// ****************************************************************
	// pci clock domain
	// ****************************************************************
	assign space_it = fifo_depth - iso_tx_stat.fifo_level;
	assign space_at = fifo_depth - async_tx_stat.fifo_level;

	always_comb begin
		s_d = s_q;
		s_d.rvalid_q = 1'b0;
		// R03 relies on software keeping this static while link runs
		s_d.pkt_sync_q = 3'h0;
		s_d.lnk_sync_q = 3'h0;
		s_d.ready_q = 1'b0;
		// R02 eeprom preload replaces defaults
		unique case (s_q.ld)
			ld_idle: begin
				s_d.ld = rom_present ? ld_run : ld_done;
			end
			ld_run: begin
				if (!rom_present)
					s_d.ld = ld_done;
				else if (rom_valid) begin
					// R22 masked load
					if (rom_slot == `ROM_SLOT_ISO)
						s_d.iso_q = rom_data & `ISO_CTRL_MASK;
					else if (rom_slot == `ROM_SLOT_ASYNC)
						s_d.async_q = rom_data & `ASYNC_CTRL_MASK;
					else if (rom_slot == `ROM_SLOT_LINK)
						s_d.link_q = rom_data & `LINK_OPT_MASK;
					else
						s_d.ld = ld_done;
				end
			end
			ld_done: begin
			end
		endcase
		// R01 upper half decode
		if (reg_req.sel && reg_req.addr[11] && s_q.ld == ld_done) begin
			s_d.rvalid_q = !reg_req.wr;
			s_d.rdata_q = 32'h0000_0000;
			unique case (reg_req.addr)
				`ISO_CTRL_OFS: begin
					// R22 unassigned bits dropped
					if (reg_req.wr)
						s_d.iso_q = reg_req.wdata & `ISO_CTRL_MASK;
					s_d.rdata_q = s_q.iso_q;
				end
				`ASYNC_CTRL_OFS: begin
					if (reg_req.wr)
						s_d.async_q = reg_req.wdata & `ASYNC_CTRL_MASK;
					s_d.rdata_q = s_q.async_q;
				end
				`LINK_OPT_OFS: begin
					if (reg_req.wr)
						s_d.link_q = reg_req.wdata & `LINK_OPT_MASK;
					s_d.rdata_q = s_q.link_q;
				end
				default: begin
				end
			endcase
		end
		// R05 R06 iso transmit request
		s_d.iso_tx_q.bus_req = tx_req(s_q.iso_q[`TX_LEVEL_LSB +: 4], iso_tx_stat);
		// R04 R21 iso transmit burst
		s_d.iso_tx_q.burst = trim_burst(s_q.iso_q[`TX_BURST_LSB +: 4], iso_tx_stat,
			{6'h00, space_it});
		// R08 R09 iso receive request
		s_d.iso_rx_q.bus_req = rx_req(s_q.iso_q[`RX_LEVEL_LSB +: 4], iso_rx_stat);
		// R07 R21 iso receive burst
		s_d.iso_rx_q.burst = trim_burst(s_q.iso_q[`RX_BURST_LSB +: 4], iso_rx_stat,
			{6'h00, iso_rx_stat.fifo_level});
		// R14 R15 async transmit request
		s_d.async_tx_q.bus_req = tx_req(s_q.async_q[`TX_LEVEL_LSB +: 4], async_tx_stat);
		// R13 R21 async transmit burst
		s_d.async_tx_q.burst = trim_burst(s_q.async_q[`TX_BURST_LSB +: 4], async_tx_stat,
			{6'h00, space_at});
		// R17 R18 async receive request
		s_d.async_rx_q.bus_req = rx_req(s_q.async_q[`RX_LEVEL_LSB +: 4], async_rx_stat);
		// R16 R21 async receive burst
		s_d.async_rx_q.burst = trim_burst(s_q.async_q[`RX_BURST_LSB +: 4], async_rx_stat,
			{6'h00, async_rx_stat.fifo_level});
		// held while loading, so no engine runs on half-loaded values
		if (s_q.ld != ld_done) begin
			s_d.iso_tx_q.bus_req = 1'b0;
			s_d.iso_rx_q.bus_req = 1'b0;
			s_d.async_tx_q.bus_req = 1'b0;
			s_d.async_rx_q.bus_req = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.ld <= ld_idle;
			// R19 R20 reset values
			s_q.iso_q <= `ISO_CTRL_RESET;
			s_q.async_q <= `ASYNC_CTRL_RESET;
			s_q.link_q <= `LINK_OPT_RESET;
			s_q.rdata_q <= 32'h0000_0000;
			s_q.rvalid_q <= 1'b0;
			s_q.iso_tx_q <= '0;
			s_q.iso_rx_q <= '0;
			s_q.async_tx_q <= '0;
			s_q.async_rx_q <= '0;
			s_q.pkt_sync_q <= 3'h0;
			s_q.lnk_sync_q <= 3'h0;
			s_q.ready_q <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// quasi-static word handed to the link domain after load
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			async_snap_q <= `ASYNC_CTRL_RESET;
		else
			async_snap_q <= s_q.async_q;
	end

	assign reg_rdata = s_q.rdata_q;
	assign reg_rvalid = s_q.rvalid_q;
	assign rom_busy = s_q.ld != ld_done;
	assign iso_tx_grant = s_q.iso_tx_q;
	assign iso_rx_grant = s_q.iso_rx_q;
	assign async_tx_grant = s_q.async_tx_q;
	assign async_rx_grant = s_q.async_rx_q;

endmodule

// [dma_burst_threshold_control_tb.sv]
`timescale 1ns/1ps
// ********
// register, engine and link tests
// ********
module dma_burst_threshold_control_tb import dma_burst_pkg::*;;
	logic sys_clk = 0, rst_n = 0, link_clk = 0, link_rst_n = 0;
	logic rom_present = 1, rom_valid = 0, rvalid, rom_busy, rdy, ok;
	logic [1:0] rom_slot = 2'h0;
	logic [31:0] rom_data = 32'h0, rdata, d;
	reg_req_type req;
	dma_stat_type st = '0;
	link_stat_type ls = '0;
	dma_grant_type itg, irg, atg, arg;
	int bad_count = 0, comparisons = 0;
	initial forever #10 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #40 link_clk = ~link_clk;
	end
	pci_host_model pci_host_model_inst (.sys_clk(sys_clk), .reg_req(req), .reg_rdata(rdata),
		.reg_rvalid(rvalid));
	dma_burst_threshold_control dma_burst_threshold_control_inst (.sys_clk(sys_clk),
		.rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.rom_present(rom_present), .rom_valid(rom_valid), .rom_slot(rom_slot),
		.rom_data(rom_data), .rom_busy(rom_busy), .iso_tx_stat(st), .iso_rx_stat(st),
		.async_tx_stat(st), .async_rx_stat(st), .iso_tx_grant(itg), .iso_rx_grant(irg),
		.async_tx_grant(atg), .async_rx_grant(arg), .link_clk(link_clk),
		.link_rst_n(link_rst_n), .link_stat(ls), .async_tx_ready(rdy));
	task automatic close_out;
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		pci_host_model_inst.rd(a, d, ok);
		chk("rvalid", 1, {31'h0, ok});
		chk("rdata", e, d);
	endtask
	// all four engines see one status; expected {bus_req, burst} per engine
	task automatic eng(input int fl, rem, bl, ln, w, input logic [9:0] it, ir, at, ar);
		@(posedge sys_clk);
		st <= '{10'(fl), 16'(rem), 16'(bl), 10'd1000, 5'(ln), 1'(w)};
		@(posedge sys_clk);
		#1;
		chk("iso_tx", {22'h0, it}, {22'h0, itg});
		chk("iso_rx", {22'h0, ir}, {22'h0, irg});
		chk("async_tx", {22'h0, at}, {22'h0, atg});
		chk("async_rx", {22'h0, ar}, {22'h0, arg});
	endtask
	task automatic lchk(input int f, w, r, e);
		@(posedge link_clk);
		ls <= '{10'(f), 10'd40, 1'(w), 1'(r)};
		repeat (2) @(posedge link_clk);
		#1;
		chk("ready", e, {31'h0, rdy});
	endtask
	initial begin
		#50000;
		bad_count++;
		close_out;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1;
		link_rst_n <= 1;
		repeat (2) @(posedge sys_clk);
		rom_valid <= 1;
		rom_slot <= 2'h2;
		rom_data <= 32'h8;
		@(posedge sys_clk);
		rom_slot <= 2'h3;
		@(posedge sys_clk);
		rom_valid <= 0;
		repeat (20) if (rom_busy !== 1'b0) @(negedge sys_clk);
		chk("rom_busy", 0, {31'h0, rom_busy});
		rchk(12'h840, 32'h8);
		rchk(12'h800, 32'h7373);
		rchk(12'h808, 32'h10_7373);
		pci_host_model_inst.rd(12'h004, d, ok);
		chk("low half", 0, {31'h0, ok});
		rchk(12'h804, 0);
		pci_host_model_inst.wr(12'h800, 32'hffff_ffff);
		pci_host_model_inst.wr(12'h808, 32'hffff_ffff);
		rchk(12'h800, 32'hffff);
		rchk(12'h808, 32'h1ff_ffff);
		pci_host_model_inst.wr(12'h808, 32'h10_7373);
		pci_host_model_inst.wr(12'h800, 32'hf000);
		eng(16, 1000, 1000, 0, 0, 10'h300, 10'h210, 10'h280, 10'h010);
		eng(15, 1000, 1000, 0, 0, 10'h300, 10'h00f, 10'h280, 10'h00f);
		eng(500, 1000, 1000, 0, 0, 10'h00c, 10'h210, 10'h00c, 10'h280);
		eng(500, 5, 1000, 0, 0, 10'h20c, 10'h210, 10'h20c, 10'h280);
		eng(5, 1000, 3, 0, 0, 10'h203, 10'h203, 10'h203, 10'h203);
		eng(5, 1000, 1000, 0, 1, 10'h300, 10'h205, 10'h280, 10'h205);
		eng(100, 1000, 1000, 16, 0, 10'h300, 10'h210, 10'h280, 10'h260);
		lchk(256, 0, 0, 1);
		lchk(255, 0, 0, 0);
		lchk(255, 1, 0, 1);
		lchk(0, 0, 0, 0);
		pci_host_model_inst.wr(12'h808, 32'h108_7373);
		repeat (8) @(posedge link_clk);
		lchk(128, 0, 0, 1);
		lchk(128, 0, 1, 0);
		lchk(511, 0, 1, 0);
		lchk(512, 0, 1, 1);
		close_out;
	end
endmodule

// [pci_host_model.sv]
`timescale 1ns/1ps
// ********
// host register access
// ********
module pci_host_model
	import dma_burst_pkg::*;
(
	// pci side
	input wire logic sys_clk,
	output reg_req_type reg_req,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial reg_req = '{1'b0, 1'b0, 12'h0, 32'h0};
	// config only written while link idle
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_req <= '{1'b1, 1'b1, a, d};
		@(posedge sys_clk);
		// released lines carry the inverse, never a stale copy
		reg_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
		@(posedge sys_clk);
		reg_req <= '{1'b1, 1'b0, a, 32'h0};
		@(posedge sys_clk);
		reg_req <= '{1'b0, 1'b0, ~a, 32'hffff_ffff};
		#1;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask
endmodule
